// >>> ilas_link_regs.sv
// Per-link lane-alignment capture and link parameter register bank.
// Assumes the link receiver core runs on clk_sys and pulses its capture
// strobes for one cycle when the alignment sequence of a lane is seen.
//
// Operation
// - Every register but the link page banked per link, page-selected.
// - Capture lanes 6/7 received lane id.
// - Store lanes 6/7 received checksum octet.
// - Compute lanes 6/7 own configuration checksum.
// - Device identifier read/write, resets zero.
// - Bank identifier read/write, resets zero.
// - Adjust direction bit, link 0 only.
// - Phase adjust request bit, link 0 only.
// - Lane identifier field, five bits, read/write.
// - Descramble enable bit, resets to one.
// - Lane count minus one, resets seven.
// - Octets per frame minus one, resets zero.
// - Frames per multiframe minus one, resets 0x1F.
//
// Our own choice: the strobed register port.
`default_nettype none
module ilas_link_regs
    import ilas_regs_pkg::*;
#(
    parameter int NUM_LINKS = 2
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    // Capture from the link receiver core, lane 6
    input wire logic lane6_capture,
    input wire logic lane6_capture_link,
    input wire logic [4:0] lane6_captured_lane_id,
    input wire logic [7:0] lane6_received_checksum,
    // Capture from the link receiver core, lane 7
    input wire logic lane7_capture,
    input wire logic lane7_capture_link,
    input wire logic [4:0] lane7_captured_lane_id,
    input wire logic [7:0] lane7_received_checksum,
    // Sum of the link parameter fields held outside this bank
    input wire logic [7:0] other_fields_sum,
    // Link parameters toward the link receiver core, link n at slice n
    output logic [NUM_LINKS*8-1:0] device_id,
    output logic [NUM_LINKS*8-1:0] bank_id,
    output logic [NUM_LINKS*5-1:0] lane_identifier_field,
    output logic [NUM_LINKS-1:0] descramble_en,
    output logic [NUM_LINKS*5-1:0] lane_count_m1,
    output logic [NUM_LINKS*8-1:0] octets_per_frame_m1,
    output logic [NUM_LINKS*5-1:0] frames_per_mf_m1,
    // Link 0 only controls toward the converter
    output logic lmfc_adjust_dir,
    output logic phase_adjust_req
);

    // The page selector is one bit wide, so at most two copies exist
    if (NUM_LINKS < 1 || NUM_LINKS > 2) begin : g_bad_links
        $error("NUM_LINKS must be 1 or 2");
    end

    typedef struct packed {
        logic [4:0] l6_lane_id;
        logic [7:0] l6_rx_chk;
        logic [7:0] l6_calc_chk;
        logic [4:0] l7_lane_id;
        logic [7:0] l7_rx_chk;
        logic [7:0] l7_calc_chk;
        logic [7:0] dev_id;
        logic [7:0] bnk_id;
        logic adj_dir;
        logic ph_adj;
        logic [4:0] lane_id;
        logic scr_en;
        logic [4:0] lanes_m1;
        logic [7:0] octets_m1;
        logic [4:0] frames_m1;
    } link_regs_t;

    typedef struct packed {
        logic page;
        link_regs_t [NUM_LINKS-1:0] links;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t state_q;
    state_t state_d;

    // Configuration checksum of one lane: octet sum of the link fields
    function automatic logic [7:0] calc_checksum(input link_regs_t r,
                                                 input logic [4:0] lid,
                                                 input logic [7:0] rest);
        logic [7:0] s;
        s = r.dev_id + r.bnk_id + {3'h0, lid};
        s = s + {7'h00, r.ph_adj} + {7'h00, r.adj_dir};
        s = s + {3'h0, r.lanes_m1} + {7'h00, r.scr_en};
        s = s + r.octets_m1 + {3'h0, r.frames_m1} + rest;
        return s;
    endfunction

    function automatic link_regs_t link_reset();
        link_regs_t r;
        r = '0;
        r.scr_en = RST_DESCRAMBLE;
        r.lanes_m1 = RST_LANES_M1;
        r.frames_m1 = RST_FRAMES_M1;
        return r;
    endfunction

    function automatic logic [DATA_W-1:0] read_value(input link_regs_t r,
                                                     input logic [11:0] a,
                                                     input logic page);
        logic [7:0] v;
        v = RST_ZERO;
        case (a)
            OFS_LINK_PAGE: v[LINK_PAGE_BIT] = page;
            OFS_L6_LANE_ID: v = {3'h0, r.l6_lane_id};
            OFS_L6_RX_CHK: v = r.l6_rx_chk;
            OFS_L6_CALC_CHK: v = r.l6_calc_chk;
            OFS_L7_LANE_ID: v = {3'h0, r.l7_lane_id};
            OFS_L7_RX_CHK: v = r.l7_rx_chk;
            OFS_L7_CALC_CHK: v = r.l7_calc_chk;
            OFS_DEVICE_ID: v = r.dev_id;
            OFS_BANK_ID: v = r.bnk_id;
            OFS_LANE_ADJ: begin
                v[ADJ_DIR_BIT] = r.adj_dir;
                v[PH_ADJ_BIT] = r.ph_adj;
                v[LANE_FIELD_W-1:0] = r.lane_id;
            end
            OFS_SCR_LANES: begin
                v[DESCRAMBLE_BIT] = r.scr_en;
                v[LANE_FIELD_W-1:0] = r.lanes_m1;
            end
            OFS_OCTETS: v = r.octets_m1;
            OFS_FRAMES: v[LANE_FIELD_W-1:0] = r.frames_m1;
            default: v = RST_ZERO;
        endcase
        return v;
    endfunction

    always_comb begin
        link_regs_t cur;
        cur = state_q.links[state_q.page];
        state_d = state_q;
        state_d.rdata = RST_ZERO;
        if (reg_read) begin
            state_d.rdata = read_value(cur, reg_addr, state_q.page);
        end
        if (reg_write) begin
            cur = state_d.links[state_q.page];
            case (reg_addr)
                OFS_LINK_PAGE: begin
                    if (NUM_LINKS > 1) begin
                        state_d.page = reg_wdata[LINK_PAGE_BIT];
                    end
                end
                OFS_DEVICE_ID: cur.dev_id = reg_wdata;
                OFS_BANK_ID: cur.bnk_id = reg_wdata;
                OFS_LANE_ADJ: begin
                    // Adjust controls exist for link 0 only
                    if (state_q.page == 1'b0) begin
                        cur.adj_dir = reg_wdata[ADJ_DIR_BIT];
                        cur.ph_adj = reg_wdata[PH_ADJ_BIT];
                    end
                    cur.lane_id = reg_wdata[LANE_FIELD_W-1:0];
                end
                OFS_SCR_LANES: begin
                    cur.scr_en = reg_wdata[DESCRAMBLE_BIT];
                    cur.lanes_m1 = reg_wdata[LANE_FIELD_W-1:0];
                end
                OFS_OCTETS: cur.octets_m1 = reg_wdata;
                OFS_FRAMES: begin
                    cur.frames_m1 = reg_wdata[LANE_FIELD_W-1:0];
                end
                default: cur = cur;
            endcase
            state_d.links[state_q.page] = cur;
        end
        // Captures land in the copy of the link that saw them
        if (lane6_capture && (NUM_LINKS > 1 || !lane6_capture_link)) begin
            cur = state_d.links[lane6_capture_link];
            cur.l6_lane_id = lane6_captured_lane_id;
            cur.l6_rx_chk = lane6_received_checksum;
            cur.l6_calc_chk = calc_checksum(cur, lane6_captured_lane_id,
                                            other_fields_sum);
            state_d.links[lane6_capture_link] = cur;
        end
        if (lane7_capture && (NUM_LINKS > 1 || !lane7_capture_link)) begin
            cur = state_d.links[lane7_capture_link];
            cur.l7_lane_id = lane7_captured_lane_id;
            cur.l7_rx_chk = lane7_received_checksum;
            cur.l7_calc_chk = calc_checksum(cur, lane7_captured_lane_id,
                                            other_fields_sum);
            state_d.links[lane7_capture_link] = cur;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q.page <= 1'b0;
            state_q.rdata <= RST_ZERO;
            for (int i = 0; i < NUM_LINKS; i++) begin
                state_q.links[i] <= link_reset();
            end
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rdata = state_q.rdata;
    assign lmfc_adjust_dir = state_q.links[0].adj_dir;
    assign phase_adjust_req = state_q.links[0].ph_adj;

    for (genvar g = 0; g < NUM_LINKS; g++) begin : g_out
        assign device_id[g*8 +: 8] = state_q.links[g].dev_id;
        assign bank_id[g*8 +: 8] = state_q.links[g].bnk_id;
        assign lane_identifier_field[g*5 +: 5] = state_q.links[g].lane_id;
        assign descramble_en[g] = state_q.links[g].scr_en;
        assign lane_count_m1[g*5 +: 5] = state_q.links[g].lanes_m1;
        assign octets_per_frame_m1[g*8 +: 8] = state_q.links[g].octets_m1;
        assign frames_per_mf_m1[g*5 +: 5] = state_q.links[g].frames_m1;
    end

endmodule
`default_nettype wire

// >>> ilas_regs_pkg.sv
// Offsets, field positions and reset values of the per-link
// lane-alignment capture and link parameter register bank.
// Assumes an 12-bit byte address and 8-bit register data.
`default_nettype none
package ilas_regs_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    // Offsets
    localparam logic [11:0] OFS_LINK_PAGE = 12'h300;
    localparam logic [11:0] OFS_L6_LANE_ID = 12'h43A;
    localparam logic [11:0] OFS_L6_RX_CHK = 12'h43D;
    localparam logic [11:0] OFS_L6_CALC_CHK = 12'h43E;
    localparam logic [11:0] OFS_L7_LANE_ID = 12'h442;
    localparam logic [11:0] OFS_L7_RX_CHK = 12'h445;
    localparam logic [11:0] OFS_L7_CALC_CHK = 12'h446;
    localparam logic [11:0] OFS_DEVICE_ID = 12'h450;
    localparam logic [11:0] OFS_BANK_ID = 12'h451;
    localparam logic [11:0] OFS_LANE_ADJ = 12'h452;
    localparam logic [11:0] OFS_SCR_LANES = 12'h453;
    localparam logic [11:0] OFS_OCTETS = 12'h454;
    localparam logic [11:0] OFS_FRAMES = 12'h455;
    // Field positions
    localparam int LINK_PAGE_BIT = 0;
    localparam int ADJ_DIR_BIT = 6;
    localparam int PH_ADJ_BIT = 5;
    localparam int DESCRAMBLE_BIT = 7;
    localparam int LANE_FIELD_W = 5;
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic RST_DESCRAMBLE = 1'b1;
    localparam logic [4:0] RST_LANES_M1 = 5'h07;
    localparam logic [4:0] RST_FRAMES_M1 = 5'h1F;
endpackage
`default_nettype wire

// >>> ilas_link_regs_props.sv
// Port checker of the per-link register bank.
// Assumes one clock domain and at least two links.
`default_nettype none
module ilas_link_regs_props
    import ilas_regs_pkg::*;
#(
    parameter int NUM_LINKS = 2
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Link parameters
    input wire logic [NUM_LINKS*8-1:0] device_id,
    input wire logic [NUM_LINKS*8-1:0] bank_id,
    input wire logic [NUM_LINKS*5-1:0] lane_identifier_field,
    input wire logic [NUM_LINKS-1:0] descramble_en,
    input wire logic [NUM_LINKS*5-1:0] lane_count_m1,
    input wire logic [NUM_LINKS*5-1:0] frames_per_mf_m1,
    input wire logic lmfc_adjust_dir,
    input wire logic phase_adjust_req
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic page_q;
    logic wr_p0;
    logic wr_p1;
    assign wr_p0 = reg_write && !page_q;
    assign wr_p1 = reg_write && page_q;
    // Own copy of the page, so writes can be tied to one link
    always_ff @(posedge clk_sys) begin
        if (reset)
            page_q <= 1'b0;
        else if (reg_write && reg_addr == OFS_LINK_PAGE)
            page_q <= reg_wdata[LINK_PAGE_BIT];
    end
    a_rdata_idle: assert property (
        !$past(reg_read) |-> reg_rdata == 8'h00) else $error("rdata not idle");
    a_unmapped_read: assert property (
        reg_read && reg_addr == 12'h7FF |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_dev_id0: assert property (
        wr_p0 && reg_addr == OFS_DEVICE_ID |=> device_id[7:0] == $past(reg_wdata))
        else $error("device id write lost");
    a_bank_id1: assert property (
        wr_p1 && reg_addr == OFS_BANK_ID |=> bank_id[8+:8] == $past(reg_wdata)
        && $stable(bank_id[7:0])) else $error("bank id write wrong");
    a_adj_link0: assert property (
        wr_p0 && reg_addr == OFS_LANE_ADJ |=> {lmfc_adjust_dir,
        phase_adjust_req, lane_identifier_field[4:0]} == $past(reg_wdata[6:0]))
        else $error("lane id or adjust write wrong");
    a_adj_link1: assert property (
        wr_p1 && reg_addr == OFS_LANE_ADJ |=>
        $stable({lmfc_adjust_dir, phase_adjust_req}))
        else $error("adjust bits moved by link 1");
    a_scr_lanes: assert property (
        wr_p0 && reg_addr == OFS_SCR_LANES |=> descramble_en[0] ==
        $past(reg_wdata[7]) && lane_count_m1[4:0] == $past(reg_wdata[4:0]))
        else $error("descramble or lanes write wrong");
    a_reset_vals: assert property (
        $fell(reset) |-> descramble_en == '1 && device_id == '0 &&
        lane_count_m1[4:0] == RST_LANES_M1 && frames_per_mf_m1[4:0] == 5'h1F)
        else $error("reset values wrong");
endmodule
`default_nettype wire

// >>> lane_capture_model.sv
// Far-side model: capture strobes of lanes 6 and 7 after alignment.
// Assumes the caller waits for nothing else on the same lane.
`default_nettype none
module lane_capture_model (
    // Clock
    input wire logic clk_sys,
    // Lane 6+n strobe, link, lane id and checksum at slice n
    output logic [1:0] cap,
    output logic [1:0] link,
    output logic [9:0] lid,
    output logic [15:0] chk
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {cap, link, lid, chk} = '0;
    task automatic send(input int n, input logic l, input logic [4:0] i,
                        input logic [7:0] c);
        @(posedge clk_sys);
        cap[n] <= 1'b1;
        link[n] <= l;
        lid[n*5+:5] <= i;
        chk[n*8+:8] <= c;
        @(posedge clk_sys);
        cap[n] <= 1'b0;
        // Stale data flipped so nothing latches it by luck
        lid[n*5+:5] <= ~i;
        chk[n*8+:8] <= ~c;
    endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench of the per-link register bank, two links.
// Assumes the lane capture model drives the capture inputs.
`default_nettype none
module tb;
    import ilas_regs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [11:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] other_fields_sum = 8'h10;
    logic [7:0] reg_rdata;
    logic [1:0] cap, link, descramble_en;
    logic [9:0] lid, lane_identifier_field, lane_count_m1, frames_per_mf_m1;
    logic [15:0] chk, device_id, bank_id, octets_per_frame_m1;
    logic lmfc_adjust_dir, phase_adjust_req;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [19:0] rst_tab [13] = '{20'h43A00, 20'h43D00, 20'h43E00,
        20'h44200, 20'h44500, 20'h44600, 20'h45000, 20'h45100, 20'h45200,
        20'h45387, 20'h45400, 20'h4551F, 20'h7FF00};
    logic [19:0] w_tab [2][6] = '{'{20'h4505A, 20'h4513C, 20'h452FF,
        20'h453FF, 20'h45481, 20'h455FF}, '{20'h450A5, 20'h45101,
        20'h452FF, 20'h45303, 20'h45402, 20'h45504}};
    logic [19:0] r_tab [2][6] = '{'{20'h4505A, 20'h4513C, 20'h4527F,
        20'h4539F, 20'h45481, 20'h4551F}, '{20'h450A5, 20'h45101,
        20'h4521F, 20'h45303, 20'h45402, 20'h45504}};
    always #10 clk_sys = ~clk_sys;
    ilas_link_regs #(.NUM_LINKS(2)) ilas_link_regs_inst (.*,
        .lane6_capture(cap[0]), .lane6_capture_link(link[0]),
        .lane6_captured_lane_id(lid[4:0]), .lane6_received_checksum(chk[7:0]),
        .lane7_capture(cap[1]), .lane7_capture_link(link[1]),
        .lane7_captured_lane_id(lid[9:5]), .lane7_received_checksum(chk[15:8]));
    lane_capture_model lane_capture_model_inst (.*);
    task automatic check(input string what, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 check($sformatf("reg %h", a), reg_rdata, exp);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        foreach (rst_tab[i]) rd(rst_tab[i][19:8], rst_tab[i][7:0]);
        wr(OFS_L6_RX_CHK, 8'hFF);
        wr(12'h7FF, 8'hFF);
        rd(OFS_L6_RX_CHK, 8'h00);
        rd(12'h7FF, 8'h00);
        rd(OFS_LINK_PAGE, 8'h00);
        $display("test reset values done");
        // Ids set before traffic, as while the receiver is in soft reset
        for (int p = 0; p < 2; p++) begin
            wr(OFS_LINK_PAGE, 8'(p));
            foreach (w_tab[p][i]) wr(w_tab[p][i][19:8], w_tab[p][i][7:0]);
        end
        for (int p = 0; p < 2; p++) begin
            wr(OFS_LINK_PAGE, 8'(p));
            foreach (r_tab[p][i]) rd(r_tab[p][i][19:8], r_tab[p][i][7:0]);
        end
        rd(OFS_LINK_PAGE, 8'h01);
        check("dev ports", device_id, 16'hA55A);
        check("bank ports", bank_id, 16'h013C);
        check("lane id ports", lane_identifier_field, 16'h03FF);
        check("octets", octets_per_frame_m1, 16'h0281);
        check("frames", frames_per_mf_m1, 16'h009F);
        check("adjust", {lmfc_adjust_dir, phase_adjust_req}, 16'h3);
        check("lanes", {descramble_en, lane_count_m1}, 16'h047F);
        $display("test paged parameters done");
        lane_capture_model_inst.send(0, 1'b1, 5'h15, 8'h33);
        lane_capture_model_inst.send(1, 1'b0, 5'h0A, 8'hC4);
        rd(OFS_L6_LANE_ID, 8'h15);
        rd(OFS_L6_RX_CHK, 8'h33);
        rd(OFS_L6_CALC_CHK, 8'(8'hA5 + 8'h01 + 8'h15 + 8'h03 + 8'h02 + 8'h04 + 8'h10));
        rd(OFS_L7_LANE_ID, 8'h00);
        wr(OFS_LINK_PAGE, 8'h00);
        rd(OFS_L7_LANE_ID, 8'h0A);
        rd(OFS_L7_RX_CHK, 8'hC4);
        rd(OFS_L7_CALC_CHK, 8'(8'h5A + 8'h3C + 8'h0A + 8'h03 + 8'h1F + 8'h81 + 8'h1F + 8'h10));
        rd(OFS_L6_RX_CHK, 8'h00);
        $display("test lane capture done");
        final_report();
    end
endmodule
bind ilas_link_regs ilas_link_regs_props #(.NUM_LINKS(NUM_LINKS)) props_inst (.*);
`default_nettype wire
